// [dmiu_defines.svh]
`ifndef DMIU_DEFINES_SVH
`define DMIU_DEFINES_SVH

// register byte offsets on the avalon slave
`define DMIU_OFS_CMD    8'h00
`define DMIU_OFS_STATUS 8'h04
`define DMIU_OFS_ACC    8'h08
`define DMIU_OFS_FLAGS  8'h0C

// command word fields
`define DMIU_CMD_OP_LSB   0
`define DMIU_CMD_OP_MSB   3
`define DMIU_CMD_ADR_LSB  8
`define DMIU_CMD_ADR_MSB  15
`define DMIU_CMD_IMM_LSB  16
`define DMIU_CMD_IMM_MSB  23

// opcodes
`define DMIU_OP_MOV_AI  4'h0
`define DMIU_OP_STORE   4'h1
`define DMIU_OP_LOAD    4'h2
`define DMIU_OP_IO_RD   4'h3
`define DMIU_OP_IO_WR   4'h4
`define DMIU_OP_SNAP    4'h5
`define DMIU_OP_PRESET  4'h6
`define DMIU_OP_IDX_LD  4'h7
`define DMIU_OP_ADD_I   4'h8
`define DMIU_OP_SUB_I   4'h9

// flag register bit positions
`define DMIU_FLAG_Z  0
`define DMIU_FLAG_C  1
`define DMIU_FLAG_AC 2
`define DMIU_FLAG_OV 3

// status register bit positions
`define DMIU_STAT_BUSY 0

// reset values
`define DMIU_RST_ACC   8'h00
`define DMIU_RST_FLAGS 4'h0

`endif

// [dmiu_pkg.sv]
package dmiu_pkg;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_LD_WAIT,
      ST_IO_WAIT,
      ST_SNAP_HI,
      ST_PRE_LO,
      ST_PRE_HI,
      ST_IDX_PTR,
      ST_IDX_DATA
   } dmiu_state_t;

endpackage : dmiu_pkg

// [dmiu_flag_alu.sv]
`timescale 1ns/100ps
`include "dmiu_defines.svh"

module dmiu_flag_alu #(
   parameter int WIDTH = 8
) (
   input wire logic [WIDTH-1:0] opa,
   input wire logic [WIDTH-1:0] opb,
   input wire logic do_sub,
   output logic [WIDTH-1:0] result,
   output logic [3:0] flags
);

   logic [WIDTH:0] full;
   logic [4:0] low;
   logic [WIDTH-1:0] opb_eff;

   always_comb begin
      opb_eff = do_sub ? ~opb : opb;
      // subtraction as a plus not-b plus one; carry out inverted gives borrow
      full = {1'b0, opa} + {1'b0, opb_eff} + {{WIDTH{1'b0}}, do_sub};
      low = {1'b0, opa[3:0]} + {1'b0, opb_eff[3:0]} + {4'h0, do_sub};
      result = full[WIDTH-1:0];
      flags = 4'h0;
      flags[`DMIU_FLAG_Z] = (full[WIDTH-1:0] == '0);
      flags[`DMIU_FLAG_C] = do_sub ? ~full[WIDTH] : full[WIDTH];
      flags[`DMIU_FLAG_AC] = do_sub ? ~low[4] : low[4];
      flags[`DMIU_FLAG_OV] = (opa[WIDTH-1] == opb_eff[WIDTH-1]) &&
         (full[WIDTH-1] != opa[WIDTH-1]);
   end

endmodule : dmiu_flag_alu

// [dmiu_top.sv]
// What this block does
// - zero flag is one when an alu result is zero, else cleared
// - carry flag holds unsigned carry out on add, borrow on subtract
// - half carry flag is one on carry out of the low nibble on add, borrow into it on subtract
// - signed range flag set when result leaves signed range
// - immediate load copies the immediate byte to acc, flags kept
// - store writes acc to addressed memory byte, flags kept
// - memory load copies byte to acc, only zero flag updated
// - after memory load zero flag set exactly when byte is zero
// - io read copies register to acc, zero flag tracks value
// - io write copies acc to addressed io register, flags kept
// - counter snapshot copies 16-bit count into memory word, flags kept
// - counter preset loads count from memory word, flags kept
// - indirect load reads byte through memory pointer in two cycles
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "dmiu_defines.svh"

module dmiu_top #(
   parameter int ADDR_W = 8,
   parameter int IO_ADDR_W = 6
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [ADDR_W-1:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic mem_we,
   output logic mem_re,
   input wire logic [7:0] mem_rdata,
   output logic [IO_ADDR_W-1:0] io_addr,
   output logic [7:0] io_wdata,
   output logic io_we,
   output logic io_re,
   input wire logic [7:0] io_rdata,
   input wire logic [15:0] sixteen_bit_counter,
   output logic [15:0] counter_preset_value,
   output logic counter_preset_store
);

   // byte offset from the word index on the bus
   function automatic logic [7:0] byte_ofs(input logic [3:0] idx);
      byte_ofs = {2'b00, idx, 2'b00};
   endfunction : byte_ofs

   dmiu_pkg::dmiu_state_t state;
   dmiu_pkg::dmiu_state_t next_state;
   logic [7:0] acc;
   logic [7:0] next_acc;
   logic [3:0] flags;
   logic [3:0] next_flags;
   logic [ADDR_W-1:0] opnd;
   logic [ADDR_W-1:0] next_opnd;
   logic [7:0] hold;
   logic [7:0] next_hold;
   logic [ADDR_W-1:0] next_mem_addr;
   logic [7:0] next_mem_wdata;
   logic next_mem_we;
   logic next_mem_re;
   logic [IO_ADDR_W-1:0] next_io_addr;
   logic [7:0] next_io_wdata;
   logic next_io_we;
   logic next_io_re;
   logic [15:0] next_preset_value;
   logic next_preset_store;
   logic rd_done;
   logic next_rd_done;
   logic [31:0] next_readdata;
   logic [7:0] alu_res;
   logic [3:0] alu_flags;
   logic [7:0] imm;
   logic [3:0] op;
   logic busy;
   logic cmd_hit;
   logic cmd_take;
   logic acc_wr;
   logic flags_wr;

   assign imm = avs_writedata[`DMIU_CMD_IMM_MSB:`DMIU_CMD_IMM_LSB];
   assign op = avs_writedata[`DMIU_CMD_OP_MSB:`DMIU_CMD_OP_LSB];
   assign busy = (state != dmiu_pkg::ST_IDLE);
   assign cmd_hit = avs_write && (byte_ofs(avs_address) == `DMIU_OFS_CMD);
   // a command while busy is stalled, not dropped
   assign cmd_take = cmd_hit && !busy;
   assign acc_wr = avs_write && !busy &&
      (byte_ofs(avs_address) == `DMIU_OFS_ACC);
   assign flags_wr = avs_write && !busy &&
      (byte_ofs(avs_address) == `DMIU_OFS_FLAGS);

   // reads take two cycles so that readdata comes from a flop
   assign avs_waitrequest = (avs_read && !rd_done) ||
      (avs_write && busy);

   dmiu_flag_alu #(
      .WIDTH(8)
   ) u_alu (
      .opa(acc),
      .opb(imm),
      .do_sub(op == `DMIU_OP_SUB_I),
      .result(alu_res),
      .flags(alu_flags)
   );

   always_comb begin
      next_rd_done = avs_read && !rd_done;
      next_readdata = avs_readdata;
      if (avs_read && !rd_done) begin
         if (byte_ofs(avs_address) == `DMIU_OFS_STATUS) begin
            next_readdata = 32'h0000_0000;
            next_readdata[`DMIU_STAT_BUSY] = busy;
         end else if (byte_ofs(avs_address) == `DMIU_OFS_ACC) begin
            next_readdata = {24'h00_0000, acc};
         end else if (byte_ofs(avs_address) == `DMIU_OFS_FLAGS) begin
            next_readdata = {28'h000_0000, flags};
         end else begin
            next_readdata = 32'h0000_0000;
         end
      end
   end

   always_comb begin
      next_state = state;
      next_acc = acc;
      next_flags = flags;
      next_opnd = opnd;
      next_hold = hold;
      next_mem_addr = mem_addr;
      next_mem_wdata = mem_wdata;
      next_mem_we = 1'b0;
      next_mem_re = 1'b0;
      next_io_addr = io_addr;
      next_io_wdata = io_wdata;
      next_io_we = 1'b0;
      next_io_re = 1'b0;
      next_preset_value = counter_preset_value;
      next_preset_store = 1'b0;
      if (acc_wr) begin
         next_acc = avs_writedata[7:0];
      end
      if (flags_wr) begin
         next_flags = avs_writedata[3:0];
      end
      case (state)
         dmiu_pkg::ST_IDLE: begin
            if (cmd_take) begin
               next_opnd = avs_writedata[`DMIU_CMD_ADR_LSB +: ADDR_W];
               next_mem_addr = avs_writedata[`DMIU_CMD_ADR_LSB +: ADDR_W];
               next_io_addr = avs_writedata[`DMIU_CMD_ADR_LSB +: IO_ADDR_W];
               case (op)
                  `DMIU_OP_MOV_AI: begin
                     next_acc = imm;
                  end
                  `DMIU_OP_ADD_I, `DMIU_OP_SUB_I: begin
                     next_acc = alu_res;
                     next_flags = alu_flags;
                  end
                  `DMIU_OP_STORE: begin
                     next_mem_wdata = acc;
                     next_mem_we = 1'b1;
                  end
                  `DMIU_OP_LOAD: begin
                     next_mem_re = 1'b1;
                     next_state = dmiu_pkg::ST_LD_WAIT;
                  end
                  `DMIU_OP_IO_RD: begin
                     next_io_re = 1'b1;
                     next_state = dmiu_pkg::ST_IO_WAIT;
                  end
                  `DMIU_OP_IO_WR: begin
                     next_io_wdata = acc;
                     next_io_we = 1'b1;
                  end
                  `DMIU_OP_SNAP: begin
                     // both halves taken in one cycle so the word is coherent
                     next_mem_wdata = sixteen_bit_counter[7:0];
                     next_hold = sixteen_bit_counter[15:8];
                     next_mem_we = 1'b1;
                     next_state = dmiu_pkg::ST_SNAP_HI;
                  end
                  `DMIU_OP_PRESET: begin
                     next_mem_re = 1'b1;
                     next_state = dmiu_pkg::ST_PRE_LO;
                  end
                  `DMIU_OP_IDX_LD: begin
                     next_mem_re = 1'b1;
                     next_state = dmiu_pkg::ST_IDX_PTR;
                  end
                  default: begin
                     next_state = dmiu_pkg::ST_IDLE;
                  end
               endcase
            end
         end
         dmiu_pkg::ST_LD_WAIT: begin
            next_acc = mem_rdata;
            next_flags[`DMIU_FLAG_Z] = (mem_rdata == 8'h00);
            next_state = dmiu_pkg::ST_IDLE;
         end
         dmiu_pkg::ST_IO_WAIT: begin
            next_acc = io_rdata;
            next_flags[`DMIU_FLAG_Z] = (io_rdata == 8'h00);
            next_state = dmiu_pkg::ST_IDLE;
         end
         dmiu_pkg::ST_SNAP_HI: begin
            next_mem_addr = opnd + 1'b1;
            next_mem_wdata = hold;
            next_mem_we = 1'b1;
            next_state = dmiu_pkg::ST_IDLE;
         end
         dmiu_pkg::ST_PRE_LO: begin
            next_hold = mem_rdata;
            next_mem_addr = opnd + 1'b1;
            next_mem_re = 1'b1;
            next_state = dmiu_pkg::ST_PRE_HI;
         end
         dmiu_pkg::ST_PRE_HI: begin
            next_preset_value = {mem_rdata, hold};
            next_preset_store = 1'b1;
            next_state = dmiu_pkg::ST_IDLE;
         end
         dmiu_pkg::ST_IDX_PTR: begin
            // high pointer byte is never fetched; software keeps it zero
            next_mem_addr = mem_rdata[ADDR_W-1:0];
            next_mem_re = 1'b1;
            next_state = dmiu_pkg::ST_IDX_DATA;
         end
         dmiu_pkg::ST_IDX_DATA: begin
            next_acc = mem_rdata;
            next_state = dmiu_pkg::ST_IDLE;
         end
         default: begin
            next_state = dmiu_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= dmiu_pkg::ST_IDLE;
         acc <= `DMIU_RST_ACC;
         flags <= `DMIU_RST_FLAGS;
         opnd <= '0;
         hold <= 8'h00;
         mem_addr <= '0;
         mem_wdata <= 8'h00;
         mem_we <= 1'b0;
         mem_re <= 1'b0;
         io_addr <= '0;
         io_wdata <= 8'h00;
         io_we <= 1'b0;
         io_re <= 1'b0;
         counter_preset_value <= 16'h0000;
         counter_preset_store <= 1'b0;
         rd_done <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         state <= next_state;
         acc <= next_acc;
         flags <= next_flags;
         opnd <= next_opnd;
         hold <= next_hold;
         mem_addr <= next_mem_addr;
         mem_wdata <= next_mem_wdata;
         mem_we <= next_mem_we;
         mem_re <= next_mem_re;
         io_addr <= next_io_addr;
         io_wdata <= next_io_wdata;
         io_we <= next_io_we;
         io_re <= next_io_re;
         counter_preset_value <= next_preset_value;
         counter_preset_store <= next_preset_store;
         rd_done <= next_rd_done;
         avs_readdata <= next_readdata;
      end
   end

endmodule : dmiu_top

// [dmiu_props.sv]
`timescale 1ns/100ps
`include "dmiu_defines.svh"
module dmiu_props #(
   parameter int ADDR_W = 8,
   parameter int IO_ADDR_W = 6
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [3:0] avs_address,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_we,
   input wire logic mem_re,
   input wire logic [IO_ADDR_W-1:0] io_addr,
   input wire logic io_we,
   input wire logic io_re,
   input wire logic [15:0] sixteen_bit_counter,
   input wire logic counter_preset_store
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   logic cmd;
   logic [3:0] op;
   logic [15:0] cnt_q, next_cnt_q;
   logic [7:0] ad_q, next_ad_q;
   assign cmd = avs_write && !avs_waitrequest && avs_address == 4'h0;
   assign op = avs_writedata[3:0];
   // a new command cannot be taken while busy, so the copies stay put
   always_comb begin
      next_cnt_q = cmd ? sixteen_bit_counter : cnt_q;
      next_ad_q = cmd ? avs_writedata[15:8] : ad_q;
   end
   always_ff @(posedge core_clk) begin
      cnt_q <= next_cnt_q;
      ad_q <= next_ad_q;
   end
   imm_quiet_a: assert property (
      cmd && op == `DMIU_OP_MOV_AI |=> !(mem_we || mem_re || io_we || io_re
      || counter_preset_store) [*2]) else $error("imm load touched bus");
   store_pulse_a: assert property (
      cmd && op == `DMIU_OP_STORE |=> mem_we && mem_addr == ADDR_W'(ad_q)
      ##1 !mem_we) else $error("store pulse wrong");
   load_pulse_a: assert property (
      cmd && op == `DMIU_OP_LOAD |=> mem_re && mem_addr == ADDR_W'(ad_q)
      ##1 !mem_re) else $error("load pulse wrong");
   io_read_a: assert property (
      cmd && op == `DMIU_OP_IO_RD |=> io_re && io_addr == IO_ADDR_W'(ad_q)
      ##1 !io_re) else $error("io read pulse wrong");
   io_write_a: assert property (
      cmd && op == `DMIU_OP_IO_WR |=> io_we && io_addr == IO_ADDR_W'(ad_q)
      ##1 !io_we) else $error("io write pulse wrong");
   snap_bytes_a: assert property (
      cmd && op == `DMIU_OP_SNAP |=> mem_we && mem_addr == ADDR_W'(ad_q)
      && mem_wdata == cnt_q[7:0] ##1 mem_we && mem_wdata == cnt_q[15:8]
      && mem_addr == ADDR_W'(ad_q + 8'h01)) else $error("snapshot wrong");
   preset_reads_a: assert property (
      cmd && op == `DMIU_OP_PRESET |=> mem_re && mem_addr == ADDR_W'(ad_q)
      ##1 mem_re && mem_addr == ADDR_W'(ad_q + 8'h01) ##[1:3]
      counter_preset_store) else $error("preset sequence wrong");
   index_reads_a: assert property (
      cmd && op == `DMIU_OP_IDX_LD |=> mem_re && mem_addr == ADDR_W'(ad_q)
      ##[1:3] mem_re) else $error("indirect load sequence wrong");
endmodule : dmiu_props
bind dmiu_top dmiu_props #(.ADDR_W(ADDR_W), .IO_ADDR_W(IO_ADDR_W))
   u_dmiu_props (.core_clk, .srst, .avs_address, .avs_write,
   .avs_writedata, .avs_waitrequest, .mem_addr, .mem_wdata, .mem_we,
   .mem_re, .io_addr, .io_we, .io_re, .sixteen_bit_counter,
   .counter_preset_store);

// [dmiu_far_model.sv]
`timescale 1ns/100ps
module dmiu_far_model (
   input wire logic core_clk,
   input wire logic [7:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_we,
   input wire logic mem_re,
   output logic [7:0] mem_rdata,
   input wire logic [5:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_we,
   input wire logic io_re,
   output logic [7:0] io_rdata,
   input wire logic [15:0] counter_preset_value,
   input wire logic counter_preset_store,
   output logic [15:0] sixteen_bit_counter
);
   logic [7:0] mem [256];
   logic [7:0] io [64];
   logic [15:0] cnt = 16'h0000;
   // the engine samples read data at the edge that ends the strobe cycle,
   // so reads answer at once; idle lines show the inverse, never stale data
   assign mem_rdata = mem_re ? mem[mem_addr] : ~mem[mem_addr];
   assign io_rdata = io_re ? io[io_addr] : ~io[io_addr];
   assign sixteen_bit_counter = cnt;
   // counter held still so a snapshot has one right answer
   // plain always: the bench preloads these arrays by hierarchy
   always @(posedge core_clk) begin
      if (mem_we) mem[mem_addr] <= mem_wdata;
      if (io_we) io[io_addr] <= io_wdata;
      if (counter_preset_store) cnt <= counter_preset_value;
   end
endmodule : dmiu_far_model

// [data_move_instruction_unit_bench.sv]
`timescale 1ns/100ps
`include "dmiu_defines.svh"
module data_move_instruction_unit_bench;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rd;
   logic avs_waitrequest, mem_we, mem_re, io_we, io_re, counter_preset_store;
   logic [7:0] mem_addr, mem_wdata, mem_rdata, io_wdata, io_rdata;
   logic [5:0] io_addr;
   logic [15:0] sixteen_bit_counter, counter_preset_value;
   int bad_count = 0;
   int n_tests = 0;
   logic [3:0] t_op [6] = '{4'h8, 4'h8, 4'h8, 4'h9, 4'h9, 4'h9};
   logic [7:0] t_a [6] = '{8'h0F, 8'hFF, 8'h7F, 8'h35, 8'h10, 8'h80};
   logic [7:0] t_b [6] = '{8'h01, 8'h01, 8'h01, 8'h35, 8'h20, 8'h10};
   logic [7:0] t_r [6] = '{8'h10, 8'h00, 8'h80, 8'h00, 8'hF0, 8'h70};
   logic [3:0] t_f [6] = '{4'h4, 4'h7, 4'hC, 4'h1, 4'h2, 4'h8};
   always #2 core_clk = ~core_clk;
   dmiu_top u_dmiu_top (.core_clk, .srst, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
      .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata, .io_addr,
      .io_wdata, .io_we, .io_re, .io_rdata, .sixteen_bit_counter,
      .counter_preset_value, .counter_preset_store);
   dmiu_far_model u_dmiu_far_model (.core_clk, .mem_addr, .mem_wdata,
      .mem_we, .mem_re, .mem_rdata, .io_addr, .io_wdata, .io_we, .io_re,
      .io_rdata, .counter_preset_value, .counter_preset_store,
      .sixteen_bit_counter);
   task print_verdict;
      if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   // waitrequest is sampled at the rising edge, before that edge's updates
   task wait_grant;
      int n;
      n = 0;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) begin
         n++;
         if (n > 100) begin
            bad_count++;
            print_verdict;
         end
         @(posedge core_clk);
      end
   endtask : wait_grant
   task av_wr(input logic [7:0] ofs, input logic [31:0] d);
      avs_address <= ofs[5:2];
      avs_writedata <= d;
      avs_write <= 1'b1;
      wait_grant;
      avs_write <= 1'b0;
      @(posedge core_clk);
   endtask : av_wr
   task av_rd(input logic [7:0] ofs, output logic [31:0] d);
      avs_address <= ofs[5:2];
      avs_read <= 1'b1;
      wait_grant;
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge core_clk);
   endtask : av_rd
   task run(input logic [3:0] op, input logic [7:0] ad, input logic [7:0] im);
      av_wr(`DMIU_OFS_CMD, {8'h00, im, ad, 4'h0, op});
      rd = 32'h1;
      for (int i = 0; i < 20 && rd[0] !== 1'b0; i++) begin
         av_rd(`DMIU_OFS_STATUS, rd);
      end
      if (rd[0] !== 1'b0) begin
         bad_count++;
         print_verdict;
      end
   endtask : run
   task acc_flags(input logic [7:0] a, input logic [3:0] f);
      av_rd(`DMIU_OFS_ACC, rd);
      chk(rd, {24'h0, a});
      av_rd(`DMIU_OFS_FLAGS, rd);
      chk(rd, {28'h0, f});
   endtask : acc_flags
   task mem_chk(input logic [7:0] a, input logic [7:0] e);
      chk({24'h0, u_dmiu_far_model.mem[a]}, {24'h0, e});
   endtask : mem_chk
   initial begin
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      u_dmiu_far_model.mem[8'h0A] = 8'h00;
      u_dmiu_far_model.mem[8'h0B] = 8'h5A;
      u_dmiu_far_model.mem[8'h14] = 8'h34;
      u_dmiu_far_model.mem[8'h15] = 8'h12;
      u_dmiu_far_model.mem[8'h1E] = 8'h5B;
      u_dmiu_far_model.mem[8'h1F] = 8'h00;
      u_dmiu_far_model.mem[8'h5B] = 8'hA5;
      u_dmiu_far_model.io[5] = 8'h00;
      u_dmiu_far_model.io[6] = 8'h80;
      av_wr(`DMIU_OFS_FLAGS, 32'hF);
      run(`DMIU_OP_MOV_AI, 8'h00, 8'h3C);
      acc_flags(8'h3C, 4'hF);
      run(`DMIU_OP_STORE, 8'h28, 8'h00);
      mem_chk(8'h28, 8'h3C);
      run(`DMIU_OP_LOAD, 8'h0A, 8'h00);
      acc_flags(8'h00, 4'hF);
      run(`DMIU_OP_LOAD, 8'h0B, 8'h00);
      acc_flags(8'h5A, 4'hE);
      run(`DMIU_OP_IO_RD, 8'h05, 8'h00);
      acc_flags(8'h00, 4'hF);
      run(`DMIU_OP_IO_RD, 8'h06, 8'h00);
      run(`DMIU_OP_IO_WR, 8'h07, 8'h00);
      chk({24'h0, u_dmiu_far_model.io[7]}, 32'h80);
      acc_flags(8'h80, 4'hE);
      run(`DMIU_OP_PRESET, 8'h14, 8'h00);
      chk({16'h0, sixteen_bit_counter}, 32'h1234);
      run(`DMIU_OP_SNAP, 8'h32, 8'h00);
      mem_chk(8'h32, 8'h34);
      mem_chk(8'h33, 8'h12);
      run(`DMIU_OP_IDX_LD, 8'h1E, 8'h00);
      acc_flags(8'hA5, 4'hE);
      for (int i = 0; i < 6; i++) begin
         run(`DMIU_OP_MOV_AI, 8'h00, t_a[i]);
         run(t_op[i], 8'h00, t_b[i]);
         acc_flags(t_r[i], t_f[i]);
      end
      print_verdict;
   end
endmodule : data_move_instruction_unit_bench
